// file: gacr_top.sv
// Burst-wrap, range-doubling and power-pin control register with its effects.
// Assumes a serial front end giving one-cycle read/write strobes on a byte address,
// and pointer load/advance pulses during burst reads.
module gacr_top
	import gacr_pkg::*;
#(
	parameter logic [7:0] ZLSB_ADDR = GACR_ADDR_ZLSB_DEF
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_RD,
	output logic [7:0]       REG_RDATA,
	output logic             REG_HIT,
	input  wire logic        PTR_LOAD,
	input  wire logic        PTR_ADV,
	output logic [7:0]       READ_PTR,
	input  wire logic [1:0]  RANGE_SELECT,
	output logic [12:0]      FSR_DPS,
	output logic [14:0]      SENS_Q7,
	input  wire logic        CFG_ACTIVE,
	input  wire logic        CFG_READY,
	input  wire logic        IRQ2_LEVEL,
	input  wire logic        IRQ2_DRIVE,
	input  wire logic        PIN2_IN,
	output logic             PIN2_OUT,
	output logic             PIN2_OE_N,
	output logic             PIN2_PULLUP,
	output logic             ACTIVE_BIT,
	output logic             ACTIVE_RO,
	output gacr_mode_t       MODE
);
	logic [7:0]  ctrl;
	logic [7:0]  next_ctrl;
	logic [7:0]  next_rdata;
	logic        next_hit;
	logic [7:0]  next_ptr;
	logic [12:0] next_fsr;
	logic [14:0] next_sens;
	logic        burst_wrap_select;
	logic        ext_power_pin_enable;
	logic        range_doubling;

	function automatic logic addr_hit(input logic [7:0] a);
		return a == GACR_REG_OFFSET;
	endfunction

	assign burst_wrap_select    = ctrl[GACR_BIT_WRAP];
	assign ext_power_pin_enable = ctrl[GACR_BIT_EXTPIN];
	assign range_doubling       = ctrl[GACR_BIT_DOUBLE];

	// Register access; changing it while Active is the host's concern
	always_comb begin
		next_ctrl  = ctrl;
		next_rdata = GACR_RDATA_IDLE;
		next_hit   = 1'b0;
		if (REG_WR && addr_hit(REG_ADDR)) begin
			next_ctrl = REG_WDATA & GACR_REG_MASK;
		end
		if (REG_RD && addr_hit(REG_ADDR)) begin
			next_rdata = ctrl & GACR_REG_MASK;
			next_hit   = 1'b1;
		end
	end

	// Burst read pointer with programmable roll-over target
	always_comb begin
		next_ptr = READ_PTR;
		if (PTR_LOAD) begin
			next_ptr = REG_ADDR;
		end else if (PTR_ADV) begin
			if (READ_PTR == ZLSB_ADDR)
				next_ptr = burst_wrap_select ? GACR_ADDR_XMSB : GACR_ADDR_STATUS;
			else
				next_ptr = READ_PTR + GACR_PTR_STEP;
		end
	end

	// Full-scale range and sensitivity from range select and doubling
	always_comb begin
		next_fsr  = GACR_FSR_MAX_DPS >> RANGE_SELECT;
		next_sens = GACR_SENS_MAX_Q7 >> RANGE_SELECT;
		if (range_doubling) begin
			next_fsr  = next_fsr << 1;
			next_sens = next_sens << 1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl      <= GACR_REG_RESET;
			REG_RDATA <= GACR_RDATA_IDLE;
			REG_HIT   <= 1'b0;
			READ_PTR  <= GACR_ADDR_STATUS;
			FSR_DPS   <= GACR_FSR_MAX_DPS;
			SENS_Q7   <= GACR_SENS_MAX_Q7;
		end else begin
			ctrl      <= next_ctrl;
			REG_RDATA <= next_rdata;
			REG_HIT   <= next_hit;
			READ_PTR  <= next_ptr;
			FSR_DPS   <= next_fsr;
			SENS_Q7   <= next_sens;
		end
	end

	gacr_pwr_pin u_pwr (
		.clk        (SYS_CLK),
		.rst_n      (RST_N),
		.ext_en     (ext_power_pin_enable),
		.cfg_active (CFG_ACTIVE),
		.cfg_ready  (CFG_READY),
		.pin_in     (PIN2_IN),
		.irq_level  (IRQ2_LEVEL),
		.irq_drive  (IRQ2_DRIVE),
		.pin_out    (PIN2_OUT),
		.pin_oe_n   (PIN2_OE_N),
		.pullup_en  (PIN2_PULLUP),
		.active_bit (ACTIVE_BIT),
		.active_ro  (ACTIVE_RO),
		.mode       (MODE)
	);

	a_wrap_to_status: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!PTR_LOAD && PTR_ADV && READ_PTR == ZLSB_ADDR && !burst_wrap_select)
		|=> (READ_PTR == GACR_ADDR_STATUS))
		else $error("pointer did not wrap to status");

	a_wrap_to_xmsb: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!PTR_LOAD && PTR_ADV && READ_PTR == ZLSB_ADDR && burst_wrap_select)
		|=> (READ_PTR == GACR_ADDR_XMSB))
		else $error("pointer did not wrap to X high byte");

	a_unused_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(REG_WR && addr_hit(REG_ADDR)) ##1 (REG_RD && addr_hit(REG_ADDR) && !REG_WR)
		|=> (REG_RDATA == ($past(REG_WDATA, 2) & GACR_REG_MASK)))
		else $error("register readback wrong or unused bits set");

	a_range_plain: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!range_doubling |=> (FSR_DPS == (GACR_FSR_MAX_DPS >> $past(RANGE_SELECT))))
		else $error("undoubled range wrong");

	a_range_doubled: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		range_doubling |=> (FSR_DPS == 13'((GACR_FSR_MAX_DPS >> $past(RANGE_SELECT)) << 1))
		&& (SENS_Q7 == 15'((GACR_SENS_MAX_Q7 >> $past(RANGE_SELECT)) << 1)))
		else $error("doubled range or scale wrong");
endmodule

// file: gacr_pkg.sv
// Constants, types and field layout for the burst, range and power-pin control register.
// Assumes the serial interface decodes byte addresses and issues one-cycle strobes.
// Notes on behaviour
// - Wrap bit clear: burst read pointer returns to address 0x00 after Z low byte.
// - Wrap bit set: burst read pointer returns to address 0x01 after Z low byte.
// - Power pin enable clear: second interrupt pin works as interrupt output.
// - Power pin enable set: all interrupt settings aimed at second pin are ignored.
// - Power pin enable set: second pin becomes high-impedance power-mode input.
// - Pin level moves Active to and from the Standby or Ready captured at enable.
// - Doubling clear: full-scale range comes only from the range-select field.
// - Doubling set: every range doubles, to 500, 1000, 2000 or 4000 dps.
// - Pin enable set: active bit follows pin, is read-only, weak pull-up on.
// - Active outranks ready: 00 Standby, ready-only Ready, active set Active.
// - Range codes 0 to 3 give 62.5 down to 7.8125 mdps/LSB, doubled when set.
package gacr_pkg;
	localparam logic [7:0]  GACR_REG_OFFSET    = 8'h15;
	localparam logic [7:0]  GACR_REG_RESET     = 8'h00;
	localparam logic [7:0]  GACR_REG_MASK      = 8'h0D;
	localparam int          GACR_BIT_WRAP      = 3;
	localparam int          GACR_BIT_EXTPIN    = 2;
	localparam int          GACR_BIT_DOUBLE    = 0;
	localparam logic [7:0]  GACR_ADDR_STATUS   = 8'h00;
	localparam logic [7:0]  GACR_ADDR_XMSB     = 8'h01;
	localparam logic [7:0]  GACR_ADDR_ZLSB_DEF = 8'h06;
	localparam logic [7:0]  GACR_PTR_STEP      = 8'h01;
	localparam logic [7:0]  GACR_RDATA_IDLE    = 8'h00;
	// Widest range in dps for range code 0, before doubling
	localparam logic [12:0] GACR_FSR_MAX_DPS   = 13'h07D0;
	// Sensitivity in 1/128 mdps/LSB for range code 0 (62.5 mdps = 8000/128)
	localparam logic [14:0] GACR_SENS_MAX_Q7   = 15'h1F40;

	typedef enum logic [2:0] {
		GACR_STANDBY = 3'b001,
		GACR_READY   = 3'b010,
		GACR_ACTIVE  = 3'b100
	} gacr_mode_t;
endpackage

// file: gacr_pwr_pin.sv
// Second interrupt pin direction and operating-mode resolution.
// Assumes the pin input is synchronous and active/ready come from the mode register.
module gacr_pwr_pin
	import gacr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ext_en,
	input  wire logic       cfg_active,
	input  wire logic       cfg_ready,
	input  wire logic       pin_in,
	input  wire logic       irq_level,
	input  wire logic       irq_drive,
	output logic            pin_out,
	output logic            pin_oe_n,
	output logic            pullup_en,
	output logic            active_bit,
	output logic            active_ro,
	output gacr_mode_t      mode
);
	logic       ext_en_q;
	logic       cap_ready;
	logic       next_ext_en_q;
	logic       next_cap_ready;
	logic       next_pin_out;
	logic       next_pin_oe_n;
	logic       next_pullup_en;
	logic       next_active_bit;
	logic       next_active_ro;
	gacr_mode_t next_mode;
	logic       eff_ready;

	function automatic gacr_mode_t mode_of(input logic act, input logic rdy);
		if (act)
			return GACR_ACTIVE;
		else if (rdy)
			return GACR_READY;
		else
			return GACR_STANDBY;
	endfunction

	always_comb begin
		next_ext_en_q  = ext_en;
		next_cap_ready = cap_ready;
		eff_ready      = cfg_ready;
		if (ext_en && !ext_en_q) begin
			next_cap_ready = cfg_ready;
		end
		if (ext_en) begin
			// Captured standby/ready choice is the low-level target
			eff_ready       = (ext_en_q) ? cap_ready : cfg_ready;
			next_active_bit = pin_in;
			next_active_ro  = 1'b1;
			next_pullup_en  = 1'b1;
			next_pin_oe_n   = 1'b1;
			next_pin_out    = 1'b0;
		end else begin
			next_active_bit = cfg_active;
			next_active_ro  = 1'b0;
			next_pullup_en  = 1'b0;
			next_pin_oe_n   = ~irq_drive;
			next_pin_out    = irq_level;
		end
		next_mode = mode_of(next_active_bit, eff_ready);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_en_q   <= 1'b0;
			cap_ready  <= 1'b0;
			pin_out    <= 1'b0;
			pin_oe_n   <= 1'b1;
			pullup_en  <= 1'b0;
			active_bit <= 1'b0;
			active_ro  <= 1'b0;
			mode       <= GACR_STANDBY;
		end else begin
			ext_en_q   <= next_ext_en_q;
			cap_ready  <= next_cap_ready;
			pin_out    <= next_pin_out;
			pin_oe_n   <= next_pin_oe_n;
			pullup_en  <= next_pullup_en;
			active_bit <= next_active_bit;
			active_ro  <= next_active_ro;
			mode       <= next_mode;
		end
	end

	sequence s_enable_ready;
		$rose(ext_en) && cfg_ready;
	endsequence

	sequence s_pin_low_held;
		(ext_en && !pin_in) [*2];
	endsequence

	a_pin_input_hiz: assert property (@(posedge clk) disable iff (!rst_n)
		ext_en |=> (pin_oe_n && pullup_en && active_ro))
		else $error("power pin not released to input");

	a_irq_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		(ext_en && irq_drive) |=> (pin_oe_n && !pin_out))
		else $error("interrupt still drives power pin");

	a_irq_pin_out: assert property (@(posedge clk) disable iff (!rst_n)
		!ext_en |=> (pin_oe_n == !$past(irq_drive)) && (pin_out == $past(irq_level)))
		else $error("interrupt output not driven on pin");

	a_pin_to_ready: assert property (@(posedge clk) disable iff (!rst_n)
		(s_enable_ready ##1 s_pin_low_held) |=> (mode == GACR_READY))
		else $error("low pin did not select captured ready mode");

	a_pin_to_active: assert property (@(posedge clk) disable iff (!rst_n)
		(ext_en && pin_in) |=> (active_bit && mode == GACR_ACTIVE))
		else $error("high pin did not select active mode");

	a_active_priority: assert property (@(posedge clk) disable iff (!rst_n)
		(!ext_en && cfg_active && cfg_ready) |=> (mode == GACR_ACTIVE))
		else $error("ready outranked active");
endmodule

// file: gacr_pin_model.sv
// Wire on the second interrupt pin, with an accelerometer that may drive it.
// Assumes an active-low device output enable and one system clock.
module gacr_pin_model (
	input  wire logic clk,
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	input  wire logic pull_en,
	input  wire logic acc_level,
	input  wire logic acc_oe,
	output logic      level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic float_pat = 1'b0;
	always @(posedge clk) float_pat <= ~float_pat;
	// An undriven, unpulled wire never keeps a stale value
	always_comb begin
		if (!dev_oe_n) level = dev_out;
		else if (acc_oe) level = acc_level;
		else if (pull_en) level = 1'b1;
		else level = float_pat;
	end
endmodule

// file: tb.sv
// Self-checking bench for the burst, range and power-pin control register.
// Assumes gacr_top and gacr_pin_model; inputs change 1 ns after each rising edge.
module tb import gacr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ld = 0, adv = 0;
	logic        ca = 0, cr = 0, il = 0, idrv = 0, acc_lvl = 0, acc_oe = 0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, ptr;
	logic [1:0]  rsel = 2'h0;
	logic        hit, p_in, p_out, p_oe_n, p_pu, act, act_ro;
	logic [12:0] fsr;
	logic [14:0] sens;
	gacr_mode_t  mode;
	int          mismatches = 0, checks = 0, cycles = 0;

	gacr_top #(.ZLSB_ADDR(GACR_ADDR_ZLSB_DEF)) dut (.SYS_CLK(clk), .RST_N(rst_n),
		.REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
		.REG_HIT(hit), .PTR_LOAD(ld), .PTR_ADV(adv), .READ_PTR(ptr), .RANGE_SELECT(rsel),
		.FSR_DPS(fsr), .SENS_Q7(sens), .CFG_ACTIVE(ca), .CFG_READY(cr), .IRQ2_LEVEL(il),
		.IRQ2_DRIVE(idrv), .PIN2_IN(p_in), .PIN2_OUT(p_out), .PIN2_OE_N(p_oe_n),
		.PIN2_PULLUP(p_pu), .ACTIVE_BIT(act), .ACTIVE_RO(act_ro), .MODE(mode));
	gacr_pin_model host_pin (.clk(clk), .dev_out(p_out), .dev_oe_n(p_oe_n), .pull_en(p_pu),
		.acc_level(acc_lvl), .acc_oe(acc_oe), .level(p_in));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic h);
		addr = a;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		chk("rdata", 15'(e), 15'(rdata));
		chk("hit", 15'(h), 15'(hit));
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			report_and_stop();
		end
	end

	initial begin
		step(3);
		rst_n = 1'b1;
		chk("fsr", 15'(13'd2000), 15'(fsr));
		chk("ptr", 15'h0000, 15'(ptr));
		chk("mode", 15'h0001, 15'(mode));
		rd_reg(GACR_REG_OFFSET, 8'h00, 1'b1);
		wr_reg(GACR_REG_OFFSET, 8'hFF);
		rd_reg(GACR_REG_OFFSET, 8'h0D, 1'b1);
		wr_reg(8'h16, 8'h00);
		rd_reg(8'h16, 8'h00, 1'b0);
		step(1);
		rd_reg(GACR_REG_OFFSET, 8'h0D, 1'b1);
		for (int d = 0; d < 2; d++) begin
			wr_reg(GACR_REG_OFFSET, 8'(d));
			for (int c = 0; c < 4; c++) begin
				rsel = 2'(c);
				step(2);
				chk("fsr", 15'((13'd2000 >> c) << d), 15'(fsr));
				chk("sens", (15'd8000 >> c) << d, sens);
			end
		end
		for (int w = 0; w < 2; w++) begin
			wr_reg(GACR_REG_OFFSET, 8'(w << 3));
			step(1);
			addr = GACR_ADDR_ZLSB_DEF - 8'h01;
			ld = 1'b1;
			step(1);
			ld = 1'b0;
			adv = 1'b1;
			step(1);
			chk("ptr", 15'(GACR_ADDR_ZLSB_DEF), 15'(ptr));
			step(1);
			adv = 1'b0;
			chk("ptr", 15'(w), 15'(ptr));
		end
		il = 1'b1;
		idrv = 1'b1;
		for (int m = 0; m < 4; m++) begin
			{ca, cr} = 2'(m);
			step(2);
			chk("mode", m[1] ? 15'h0004 : (m[0] ? 15'h0002 : 15'h0001), 15'(mode));
		end
		chk("oe_n", 15'h0000, 15'(p_oe_n));
		chk("pin_out", 15'h0001, 15'(p_out));
		ca = 1'b0;
		wr_reg(GACR_REG_OFFSET, 8'h04);
		step(1);
		cr = 1'b0;
		step(2);
		chk("oe_n", 15'h0001, 15'(p_oe_n));
		chk("pin_out", 15'h0000, 15'(p_out));
		chk("pullup", 15'h0001, 15'(p_pu));
		chk("act_ro", 15'h0001, 15'(act_ro));
		chk("mode", 15'h0004, 15'(mode));
		acc_oe = 1'b1;
		step(2);
		chk("mode", 15'h0002, 15'(mode));
		chk("act", 15'h0000, 15'(act));
		acc_lvl = 1'b1;
		step(2);
		chk("act", 15'h0001, 15'(act));
		wr_reg(GACR_REG_OFFSET, 8'h00);
		step(1);
		acc_lvl = 1'b0;
		wr_reg(GACR_REG_OFFSET, 8'h04);
		step(2);
		chk("mode", 15'h0001, 15'(mode));
		acc_lvl = 1'b1;
		step(2);
		chk("mode", 15'h0004, 15'(mode));
		// Enable again with ready chosen and the pin held low from the start
		wr_reg(GACR_REG_OFFSET, 8'h00);
		step(1);
		cr = 1'b1;
		acc_lvl = 1'b0;
		wr_reg(GACR_REG_OFFSET, 8'h04);
		step(4);
		chk("mode", 15'h0002, 15'(mode));
		chk("act", 15'h0000, 15'(act));
		report_and_stop();
	end
endmodule
